// file: rtl/line_editor_pkg.sv
// constants shared by the terminal line editor and its output queue
// assumes one 100 MHz system clock and an active-low asynchronous reset
package line_editor_pkg;

   // ****************************************
   // widths and depths
   // ****************************************
   localparam int DATA_W = 8;
   localparam int LINE_MAX = 128;
   localparam int LINE_AW = 8;
   localparam int IDX_W = 7;
   localparam int OUTQ_DEPTH = 16;
   localparam int OUTQ_AW = 4;
   localparam int SEQ_LEN = 6;
   localparam int SEQ_W = 48;
   localparam int SEQN_W = 3;

   // ****************************************
   // character codes
   // ****************************************
   localparam logic [7:0] CH_CMD_DFLT = 8'h03;
   localparam logic [7:0] CH_CANCEL_DFLT = 8'h18;
   localparam logic [7:0] CH_RETYPE_DFLT = 8'h12;
   localparam logic [7:0] CH_STOP_DFLT = 8'h13;
   localparam logic [7:0] CH_START_DFLT = 8'h11;
   localparam logic [7:0] CH_PASS_DFLT = 8'h16;
   localparam logic [7:0] CH_BS = 8'h08;
   localparam logic [7:0] CH_DEL = 8'h7F;
   localparam logic [7:0] CH_CR = 8'h0D;
   localparam logic [7:0] CH_SP = 8'h20;
   localparam logic [7:0] CH_BSL = 8'h5C;
   // prompt text, first character in the low byte
   localparam logic [31:0] PROMPT = {8'h3A, 8'h64, 8'h6D, 8'h63};
   localparam logic [SEQN_W-1:0] PROMPT_N = 3'h4;

   // ****************************************
   // register map
   // ****************************************
   localparam int REG_AW = 4;
   localparam logic [3:0] REG_CMD_CHAR = 4'h0;
   localparam logic [3:0] REG_CANCEL_CHAR = 4'h1;
   localparam logic [3:0] REG_RETYPE_CHAR = 4'h2;
   localparam logic [3:0] REG_STOP_CHAR = 4'h3;
   localparam logic [3:0] REG_START_CHAR = 4'h4;
   localparam logic [3:0] REG_PASS_CHAR = 4'h5;
   localparam logic [3:0] REG_CONFIG = 4'h6;
   localparam logic [3:0] REG_STATUS = 4'h7;
   localparam logic [3:0] REG_PREV_CODE = 4'h8;
   localparam logic [3:0] REG_LINE_LEN = 4'h9;
   localparam int CFG_RUBOUT_BIT = 0;
   localparam int CFG_FIX_BIT = 1;
   localparam int CFG_CONV_BIT = 2;
   localparam logic RUBOUT_RST = 1'b0;
   localparam logic FIX_RST = 1'b1;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EMIT = 3'b010,
      ST_RETYPE = 3'b100
   } edit_state_e;

endpackage : line_editor_pkg

// file: rtl/echo_fifo.sv
// output character queue of the terminal line editor
// assumes push is never asked of a full queue nor pop of an empty one
`timescale 1ns/1ps
module echo_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   parameter int AW = 4
) (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic push_i,
   input wire logic [WIDTH-1:0] push_data_i,
   input wire logic pop_i,
   output logic [WIDTH-1:0] pop_data_o,
   output logic full_o,
   output logic empty_o
);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;

   assign full_o = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   assign empty_o = (wr_q == rd_q);
   assign pop_data_o = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push_i && !full_o) begin
            wr_q <= (AW+1)'(wr_q + 1'b1);
         end
         if (pop_i && !empty_o) begin
            rd_q <= (AW+1)'(rd_q + 1'b1);
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (push_i && !full_o) begin
         mem_q[wr_q[AW-1:0]] <= push_data_i;
      end
   end

endmodule : echo_fifo

// file: rtl/terminal_line_editor.sv
// terminal-side input handler: mode switching, line editing, echo and flow control
// assumes host characters arrive synchronous to core_clk_i with a valid/ready handshake
//
// Notes on behaviour
// - the command-entry character (default 0x03) takes conversation mode to command mode.
// - a break on the host line does the same as the command-entry character.
// - the command-entry character in command mode does nothing and keeps the typed line.
// - each special character is set by code and the previous code is kept for readback.
// - the editing characters work in both modes unless noted otherwise.
// - rubout selection picks delete (0x7F) when on and backspace when off as the erase key.
// - with display fix on an erase echoes backspace, space, backspace.
// - with display fix off an erase echoes one backslash.
// - the cancel-line character drops the line and echoes backslash and carriage return.
// - a cancel in command mode is followed by a fresh prompt.
// - the retype character echoes backslash, line break, cmd: in command mode, then the current line.
// - the stop character halts output to the host and the start character resumes it.
// - in conversation mode carriage return sends the packet unless it was passed.
// - any character after the pass character is stored literally.
// - the command-entry character is not echoed; a prompt is shown instead.
// - the pass character is programmable like the others.
`timescale 1ns/1ps
module terminal_line_editor
   import line_editor_pkg::*;
(
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_break_i,
   output logic rx_ready_o,
   output logic tx_valid_o,
   output logic [7:0] tx_data_o,
   input wire logic tx_ready_i,
   output logic pkt_send_o,
   output logic cmd_line_o,
   output logic [7:0] line_len_o,
   output logic cmd_mode_o,
   input wire logic [IDX_W-1:0] rd_idx_i,
   output logic [7:0] rd_char_o,
   input wire logic [REG_AW-1:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o
);

   // ****************************************
   // state
   // ****************************************
   logic [7:0] cmd_char_q, cancel_char_q, retype_char_q;
   logic [7:0] stop_char_q, start_char_q, pass_char_q, prev_code_q;
   logic rubout_sel_q, fix_q, cmd_mode_q, halt_q, pass_q;
   logic [7:0] line_buf_q [LINE_MAX];
   logic [LINE_AW-1:0] len_q, idx_q;
   edit_state_e state_q, state_d;
   logic [SEQ_W-1:0] seq_q, seq_d;
   logic [SEQN_W-1:0] seq_n_q, seq_n_d;
   logic retype_q, retype_d;
   logic rx_ready_q, tx_valid_q, pkt_send_q, cmd_line_q;
   logic [7:0] tx_data_q, line_len_q, rd_char_q, reg_rdata_q;
   logic take, brk_take, push, pop, q_full, q_empty;
   logic [7:0] push_data, q_data, erase_ch;
   logic act_enter, act_cancel, act_retype, act_stop, act_start;
   logic act_pass, act_erase, act_cr, act_store, room;

   assign take = rx_valid_i && rx_ready_q;
   assign brk_take = rx_break_i && rx_ready_q;
   assign erase_ch = rubout_sel_q ? CH_DEL : CH_BS;
   assign room = (len_q < LINE_AW'(LINE_MAX));

   // ****************************************
   // input classification
   // ****************************************
   // priority order settles clashes when two codes are programmed equal
   always_comb begin
      act_enter = 1'b0;
      act_cancel = 1'b0;
      act_retype = 1'b0;
      act_stop = 1'b0;
      act_start = 1'b0;
      act_pass = 1'b0;
      act_erase = 1'b0;
      act_cr = 1'b0;
      act_store = 1'b0;
      if (brk_take) begin
         act_enter = !cmd_mode_q;
      end else if (take && pass_q) begin
         act_store = 1'b1;
      end else if (take) begin
         if (rx_data_i == cmd_char_q) begin
            act_enter = !cmd_mode_q;
         end else if (rx_data_i == cancel_char_q) begin
            act_cancel = 1'b1;
         end else if (rx_data_i == retype_char_q) begin
            act_retype = 1'b1;
         end else if (rx_data_i == stop_char_q) begin
            act_stop = 1'b1;
         end else if (rx_data_i == start_char_q) begin
            act_start = 1'b1;
         end else if (rx_data_i == pass_char_q) begin
            act_pass = 1'b1;
         end else if (rx_data_i == erase_ch) begin
            act_erase = 1'b1;
         end else if (rx_data_i == CH_CR) begin
            act_cr = 1'b1;
         end else begin
            act_store = 1'b1;
         end
      end
   end

   // ****************************************
   // mode, halt and pass flags
   // ****************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_mode_q <= 1'b1;
      end else if (act_enter) begin
         cmd_mode_q <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == REG_CONFIG && reg_wdata_i[CFG_CONV_BIT]) begin
         cmd_mode_q <= 1'b0;
      end
   end

   // halt only gates the drain; input keeps flowing into the line until the queue fills
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         halt_q <= 1'b0;
      end else if (act_stop) begin
         halt_q <= 1'b1;
      end else if (act_start) begin
         halt_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pass_q <= 1'b0;
      end else if (act_pass) begin
         pass_q <= 1'b1;
      end else if (act_store || brk_take) begin
         pass_q <= 1'b0;
      end
   end

   // ****************************************
   // line buffer
   // ****************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         len_q <= '0;
      end else if (act_enter || act_cancel || act_cr) begin
         len_q <= '0;
      end else if (act_erase && len_q != '0) begin
         len_q <= LINE_AW'(len_q - 1'b1);
      end else if (act_store && room) begin
         len_q <= LINE_AW'(len_q + 1'b1);
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (act_store && room) begin
         line_buf_q[len_q[IDX_W-1:0]] <= rx_data_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pkt_send_q <= 1'b0;
         cmd_line_q <= 1'b0;
         line_len_q <= '0;
         rd_char_q <= '0;
      end else begin
         pkt_send_q <= act_cr && !cmd_mode_q;
         cmd_line_q <= act_cr && cmd_mode_q;
         if (act_cr) begin
            line_len_q <= len_q;
         end
         rd_char_q <= line_buf_q[rd_idx_i];
      end
   end

   // ****************************************
   // echo sequencer
   // ****************************************
   // every echo but the retyped line goes through the sequence register so the idle state never
   // needs room in the queue; input stalls while a sequence drains
   always_comb begin
      state_d = state_q;
      seq_d = seq_q;
      seq_n_d = seq_n_q;
      retype_d = retype_q;
      push = 1'b0;
      case (state_q)
         ST_IDLE: begin
            retype_d = 1'b0;
            state_d = ST_EMIT;
            if (act_enter) begin
               seq_d = SEQ_W'({PROMPT, CH_CR});
               seq_n_d = SEQN_W'(PROMPT_N + 1'b1);
            end else if (act_cancel) begin
               seq_d = cmd_mode_q ? {PROMPT, CH_CR, CH_BSL} : SEQ_W'({CH_CR, CH_BSL});
               seq_n_d = cmd_mode_q ? SEQN_W'(SEQ_LEN) : 3'h2;
            end else if (act_retype) begin
               seq_d = cmd_mode_q ? {PROMPT, CH_CR, CH_BSL} : SEQ_W'({CH_CR, CH_BSL});
               seq_n_d = cmd_mode_q ? SEQN_W'(SEQ_LEN) : 3'h2;
               retype_d = 1'b1;
            end else if (act_erase && len_q != '0) begin
               seq_d = fix_q ? SEQ_W'({CH_BS, CH_SP, CH_BS}) : SEQ_W'(CH_BSL);
               seq_n_d = fix_q ? 3'h3 : 3'h1;
            end else if (act_cr) begin
               seq_d = cmd_mode_q ? SEQ_W'({PROMPT, CH_CR}) : SEQ_W'(CH_CR);
               seq_n_d = cmd_mode_q ? SEQN_W'(PROMPT_N + 1'b1) : 3'h1;
            end else if (act_store && room) begin
               seq_d = SEQ_W'(rx_data_i);
               seq_n_d = 3'h1;
            end else begin
               state_d = ST_IDLE;
            end
         end
         ST_EMIT: begin
            if (!q_full) begin
               push = 1'b1;
               seq_d = seq_q >> DATA_W;
               seq_n_d = SEQN_W'(seq_n_q - 1'b1);
               if (seq_n_q == 3'h1) begin
                  state_d = retype_q ? ST_RETYPE : ST_IDLE;
               end
            end
         end
         ST_RETYPE: begin
            if (idx_q == len_q) begin
               state_d = ST_IDLE;
            end else if (!q_full) begin
               push = 1'b1;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   assign push_data = (state_q == ST_RETYPE) ? line_buf_q[idx_q[IDX_W-1:0]] : seq_q[7:0];

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         state_q <= ST_IDLE;
         seq_q <= '0;
         seq_n_q <= '0;
         retype_q <= 1'b0;
         rx_ready_q <= 1'b0;
      end else begin
         state_q <= state_d;
         seq_q <= seq_d;
         seq_n_q <= seq_n_d;
         retype_q <= retype_d;
         rx_ready_q <= (state_d == ST_IDLE);
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idx_q <= '0;
      end else if (state_q != ST_RETYPE) begin
         idx_q <= '0;
      end else if (push) begin
         idx_q <= LINE_AW'(idx_q + 1'b1);
      end
   end

   // ****************************************
   // output queue and host-facing stage
   // ****************************************
   echo_fifo #(
      .WIDTH(DATA_W),
      .DEPTH(OUTQ_DEPTH),
      .AW(OUTQ_AW)
   ) u_outq (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .push_i(push),
      .push_data_i(push_data),
      .pop_i(pop),
      .pop_data_o(q_data),
      .full_o(q_full),
      .empty_o(q_empty)
   );

   // a character already offered stays offered through a halt
   assign pop = !q_empty && !halt_q && (!tx_valid_q || tx_ready_i);

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_valid_q <= 1'b0;
         tx_data_q <= '0;
      end else if (pop) begin
         tx_valid_q <= 1'b1;
         tx_data_q <= q_data;
      end else if (tx_ready_i) begin
         tx_valid_q <= 1'b0;
      end
   end

   // ****************************************
   // register port
   // ****************************************
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_char_q <= CH_CMD_DFLT;
         cancel_char_q <= CH_CANCEL_DFLT;
         retype_char_q <= CH_RETYPE_DFLT;
         stop_char_q <= CH_STOP_DFLT;
         start_char_q <= CH_START_DFLT;
         pass_char_q <= CH_PASS_DFLT;
         prev_code_q <= '0;
         rubout_sel_q <= RUBOUT_RST;
         fix_q <= FIX_RST;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            REG_CMD_CHAR: begin
               cmd_char_q <= reg_wdata_i;
               prev_code_q <= cmd_char_q;
            end
            REG_CANCEL_CHAR: begin
               cancel_char_q <= reg_wdata_i;
               prev_code_q <= cancel_char_q;
            end
            REG_RETYPE_CHAR: begin
               retype_char_q <= reg_wdata_i;
               prev_code_q <= retype_char_q;
            end
            REG_STOP_CHAR: begin
               stop_char_q <= reg_wdata_i;
               prev_code_q <= stop_char_q;
            end
            REG_START_CHAR: begin
               start_char_q <= reg_wdata_i;
               prev_code_q <= start_char_q;
            end
            REG_PASS_CHAR: begin
               pass_char_q <= reg_wdata_i;
               prev_code_q <= pass_char_q;
            end
            REG_CONFIG: begin
               rubout_sel_q <= reg_wdata_i[CFG_RUBOUT_BIT];
               fix_q <= reg_wdata_i[CFG_FIX_BIT];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_q <= '0;
      end else if (reg_rd_i) begin
         case (reg_addr_i)
            REG_CMD_CHAR: reg_rdata_q <= cmd_char_q;
            REG_CANCEL_CHAR: reg_rdata_q <= cancel_char_q;
            REG_RETYPE_CHAR: reg_rdata_q <= retype_char_q;
            REG_STOP_CHAR: reg_rdata_q <= stop_char_q;
            REG_START_CHAR: reg_rdata_q <= start_char_q;
            REG_PASS_CHAR: reg_rdata_q <= pass_char_q;
            REG_CONFIG: reg_rdata_q <= {6'h00, fix_q, rubout_sel_q};
            REG_STATUS: reg_rdata_q <= {5'h00, pass_q, halt_q, cmd_mode_q};
            REG_PREV_CODE: reg_rdata_q <= prev_code_q;
            REG_LINE_LEN: reg_rdata_q <= len_q;
            default: reg_rdata_q <= '0;
         endcase
      end else begin
         reg_rdata_q <= '0;
      end
   end

   assign rx_ready_o = rx_ready_q;
   assign tx_valid_o = tx_valid_q;
   assign tx_data_o = tx_data_q;
   assign pkt_send_o = pkt_send_q;
   assign cmd_line_o = cmd_line_q;
   assign line_len_o = line_len_q;
   assign cmd_mode_o = cmd_mode_q;
   assign rd_char_o = rd_char_q;
   assign reg_rdata_o = reg_rdata_q;

   // ****************************************
   // checks
   // ****************************************
   property p_enter;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      take && !rx_break_i && !pass_q && !cmd_mode_q && rx_data_i == cmd_char_q
      |=> cmd_mode_q && state_q == ST_EMIT && seq_q[7:0] == CH_CR && len_q == '0;
   endproperty
   a_enter: assert property (p_enter) else $error("command entry failed");

   property p_break;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      brk_take && !cmd_mode_q |=> cmd_mode_q ##1 !rx_ready_o;
   endproperty
   a_break: assert property (p_break) else $error("break did not enter command mode");

   property p_cmd_idle;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      take && !rx_break_i && !pass_q && cmd_mode_q && rx_data_i == cmd_char_q
      |=> len_q == $past(len_q) && state_q == ST_IDLE;
   endproperty
   a_cmd_idle: assert property (p_cmd_idle) else $error("entry char acted in cmd mode");

   property p_erase_bsl;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      act_erase && !fix_q && len_q != '0
      |=> len_q == LINE_AW'($past(len_q) - 1'b1) && seq_q[7:0] == CH_BSL && seq_n_q == 3'h1;
   endproperty
   a_erase_bsl: assert property (p_erase_bsl) else $error("erase echo wrong");

   property p_erase_fix;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      act_erase && fix_q && len_q != '0 |=> seq_q[23:0] == {CH_BS, CH_SP, CH_BS};
   endproperty
   a_erase_fix: assert property (p_erase_fix) else $error("display fix echo wrong");

   property p_cancel;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      act_cancel && cmd_mode_q
      |=> len_q == '0 && seq_n_q == SEQN_W'(SEQ_LEN) && seq_q == {PROMPT, CH_CR, CH_BSL};
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel echo wrong");

   property p_send;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      act_cr && !cmd_mode_q |=> pkt_send_o && line_len_o == $past(len_q) ##1 !pkt_send_o;
   endproperty
   a_send: assert property (p_send) else $error("packet not sent on return");

   property p_pass_cr;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      take && !rx_break_i && pass_q && rx_data_i == CH_CR && room
      |=> !pkt_send_o && !pass_q && len_q == LINE_AW'($past(len_q) + 1'b1);
   endproperty
   a_pass_cr: assert property (p_pass_cr) else $error("passed char not stored");

   property p_halt;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      halt_q && !tx_valid_o |=> !tx_valid_o;
   endproperty
   a_halt: assert property (p_halt) else $error("output while halted");

   property p_prev;
      @(posedge core_clk_i) disable iff (!arst_n_i)
      reg_wr_i && reg_addr_i == REG_CMD_CHAR
      |=> prev_code_q == $past(cmd_char_q) && cmd_char_q == $past(reg_wdata_i);
   endproperty
   a_prev: assert property (p_prev) else $error("previous code not kept");

endmodule : terminal_line_editor

// file: testbench/host_term_model.sv
// host terminal model: takes echoed characters, optionally stalling at random
// assumes the bench seeds $urandom and reads the seen pulse each cycle
`timescale 1ns/1ps
module host_term_model (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic tx_valid_i,
   input wire logic [7:0] tx_data_i,
   input wire logic slow_i,
   output logic tx_ready_o,
   output logic seen_o,
   output logic [7:0] seen_data_o
);
   // ****************************************
   // accept side
   // ****************************************
   // slow mode stalls at random so held output is exercised
   always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         tx_ready_o <= 1'b0;
         seen_o <= 1'b0;
         seen_data_o <= 8'h00;
      end else begin
         tx_ready_o <= slow_i ? 1'($urandom % 2) : 1'b1;
         seen_o <= tx_valid_i & tx_ready_o;
         seen_data_o <= tx_data_i;
      end
   end
endmodule : host_term_model

// file: testbench/terminal_line_editor_tb_top.sv
// self-checking bench for the terminal line editor
// assumes the host model above sits on the echo output
`timescale 1ns/1ps
module terminal_line_editor_tb_top;
   import line_editor_pkg::*;
   logic core_clk_i = 0, arst_n_i = 0, rx_valid_i = 0, rx_break_i = 0, reg_wr_i = 0;
   logic reg_rd_i = 0, slow = 0, tx_ready_i, tx_valid_o, seen, pkt_send_o, cmd_mode_o;
   logic rx_ready_o, cmd_line_o;
   logic [7:0] rx_data_i = 0, reg_wdata_i = 0, tx_data_o, seen_data, line_len_o;
   logic [7:0] rd_char_o, reg_rdata_o, e;
   logic [7:0] c [8];
   logic [3:0] reg_addr_i = 0;
   logic [IDX_W-1:0] rd_idx_i = 0;
   logic [7:0] exp_q [$];
   int failures = 0, n_tests = 0, n_pkt = 0, n_cmdl = 0;
   // ****************************************
   // design and host
   // ****************************************
   terminal_line_editor terminal_line_editor_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i), .rx_break_i(rx_break_i),
      .rx_ready_o(rx_ready_o),
      .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i),
      .pkt_send_o(pkt_send_o), .cmd_line_o(cmd_line_o), .line_len_o(line_len_o),
      .cmd_mode_o(cmd_mode_o),
      .rd_idx_i(rd_idx_i), .rd_char_o(rd_char_o), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o));
   host_term_model host_term_model_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
      .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o), .slow_i(slow), .tx_ready_o(tx_ready_i),
      .seen_o(seen), .seen_data_o(seen_data));
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] want);
      n_tests++;
      if (got !== want) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, want);
      end
   endtask : chk
   task automatic ex(input logic [7:0] ch);
      exp_q.push_back(ch);
   endtask : ex
   // carriage return and prompt
   task automatic prm();
      ex(CH_CR);
      for (int i = 0; i < 4; i++) ex(PROMPT[8*i+:8]);
   endtask : prm
   // released with a spare edge so back-to-back calls never drive twice in one step
   task automatic send(input logic [7:0] ch, input logic brk = 1'b0);
      rx_valid_i <= !brk;
      rx_break_i <= brk;
      rx_data_i <= ch;
      do @(posedge core_clk_i); while (rx_ready_o !== 1'b1);
      rx_valid_i <= 1'b0;
      rx_break_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : send
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge core_clk_i);
      reg_wr_i <= 1'b0;
      @(posedge core_clk_i);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] want);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge core_clk_i);
      reg_rd_i <= 1'b0;
      @(posedge core_clk_i);
      chk(reg_rdata_o, want);
   endtask : rd
   task automatic settle();
      for (int i = 0; i < 400 && exp_q.size() > 0; i++) @(posedge core_clk_i);
      repeat (8) @(posedge core_clk_i);
      chk(8'(exp_q.size()), 8'h00);
   endtask : settle
   task automatic summarize();
      if (failures == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize
   // ****************************************
   // echo monitor and watchdog
   // ****************************************
   always @(posedge core_clk_i) begin
      if (pkt_send_o === 1'b1) n_pkt++;
      if (cmd_line_o === 1'b1) n_cmdl++;
      if (seen === 1'b1) begin
         e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hXX;
         chk(seen_data, e);
      end
   end
   initial begin
      repeat (20000) @(posedge core_clk_i);
      failures++;
      summarize();
   end
   // ****************************************
   // scenarios
   // ****************************************
   initial begin
      void'($urandom(32'h595B));
      repeat (5) @(posedge core_clk_i);
      chk(8'(cmd_mode_o), 8'h01);
      arst_n_i <= 1'b1;
      @(posedge core_clk_i);
      for (int a = 0; a < 6; a++) rd(4'(a), 8'(48'h161113121803 >> (8*a)));
      rd(REG_CONFIG, 8'h02);
      rd(REG_PREV_CODE, 8'h00);
      rd(4'hF, 8'h00);
      send(8'h41); ex(8'h41);
      send(8'h42); ex(8'h42);
      send(CH_CMD_DFLT);
      settle();
      rd(REG_LINE_LEN, 8'h02);
      send(CH_BS); ex(CH_BS); ex(CH_SP); ex(CH_BS);
      send(CH_CR); prm();
      settle();
      chk(line_len_o, 8'h01);
      send(8'h4B); ex(8'h4B);
      send(CH_CANCEL_DFLT); ex(CH_BSL); prm();
      settle();
      rd(REG_LINE_LEN, 8'h00);
      wr(REG_CONFIG, 8'h06);
      chk(8'(cmd_mode_o), 8'h00);
      slow <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         c[i] = 8'h41 + 8'($urandom % 26);
         send(c[i]); ex(c[i]);
      end
      c[6] = CH_CR;
      c[7] = CH_CANCEL_DFLT;
      send(CH_PASS_DFLT); send(CH_CR); ex(CH_CR);
      send(CH_PASS_DFLT); send(c[7]); ex(c[7]);
      send(CH_RETYPE_DFLT); ex(CH_BSL); ex(CH_CR);
      for (int i = 0; i < 8; i++) ex(c[i]);
      send(CH_CR); ex(CH_CR);
      settle();
      chk(line_len_o, 8'h08);
      chk(8'(n_pkt), 8'h01);
      chk(8'(n_cmdl), 8'h01);
      chk(rd_char_o, c[0]);
      rd_idx_i <= 7'h07;
      repeat (2) @(posedge core_clk_i);
      chk(rd_char_o, c[7]);
      wr(REG_CONFIG, 8'h01);
      send(8'h4D); ex(8'h4D);
      send(CH_DEL); ex(CH_BSL);
      send(CH_CANCEL_DFLT); ex(CH_BSL); ex(CH_CR);
      settle();
      send(CH_STOP_DFLT);
      send(8'h5A); ex(8'h5A);
      repeat (30) @(posedge core_clk_i);
      chk(8'(exp_q.size()), 8'h01);
      rd(REG_STATUS, 8'h02);
      send(CH_START_DFLT);
      settle();
      send(8'h00, 1'b1); prm();
      settle();
      chk(8'(cmd_mode_o), 8'h01);
      wr(REG_CMD_CHAR, 8'h05);
      rd(REG_PREV_CODE, CH_CMD_DFLT);
      wr(REG_CONFIG, 8'h04);
      send(8'h05); prm();
      settle();
      chk(8'(cmd_mode_o), 8'h01);
      wr(REG_PASS_CHAR, 8'h01);
      rd(REG_PREV_CODE, CH_PASS_DFLT);
      send(8'h01); send(CH_CANCEL_DFLT); ex(CH_CANCEL_DFLT);
      send(CH_RETYPE_DFLT); ex(CH_BSL); prm(); ex(CH_CANCEL_DFLT);
      settle();
      summarize();
   end
endmodule : terminal_line_editor_tb_top
